/* rtl/ccra_pkg.sv */
// Purpose : Constants for the CPU core status word, operand registers and arithmetic datapath
// Assumes : Single clock, synchronous active-high reset
// Notes   : Opcode classes, cycle and byte counts per instruction, register offsets and reset values
package ccra_pkg;

   // Widths
   localparam int          PC_W          = 16;
   localparam int          CNT_W         = 3;

   // Special-function register offsets
   localparam logic [7:0]  SFR_SP        = 8'h81;
   localparam logic [7:0]  SFR_DPL       = 8'h82;
   localparam logic [7:0]  SFR_DPH       = 8'h83;
   localparam logic [7:0]  SFR_PSW       = 8'hd0;
   localparam logic [7:0]  SFR_ACC       = 8'he0;
   localparam logic [7:0]  SFR_B         = 8'hf0;

   // Reset values
   localparam logic [7:0]  SP_RESET      = 8'h07;
   localparam logic [7:0]  PSW_RESET     = 8'h00;
   localparam logic [7:0]  ACC_RESET     = 8'h00;
   localparam logic [7:0]  B_RESET       = 8'h00;
   localparam logic [15:0] DATA_POINTER_16_RESET    = 16'h0000;
   localparam logic [15:0] PC_RESET      = 16'h0000;

   // Status word field positions
   localparam int          CY_BIT        = 7;
   localparam int          AC_BIT        = 6;
   localparam int          F0_BIT        = 5;
   localparam int          RS_HI         = 4;
   localparam int          RS_LO         = 3;
   localparam int          OV_BIT        = 2;
   localparam int          F1_BIT        = 1;
   localparam int          P_BIT         = 0;

   // Address areas
   localparam logic [7:0]  BIT_AREA_BASE = 8'h20;

   // Opcode groups (high nibble), low-bit operand and jump selectors, and single opcodes
   localparam logic [3:0]  GRP_ADD       = 4'h2;
   localparam logic [3:0]  GRP_ADD_WITH_CARRY_IN      = 4'h3;
   localparam logic [3:0]  GRP_SUBTRACT_WITH_BORROW      = 4'h9;
   localparam logic [3:0]  GRP_AND       = 4'h5;
   localparam logic [3:0]  LO_IMM        = 4'h4;
   localparam logic [3:0]  LO_DIR        = 4'h5;
   localparam logic [4:0]  AJMP_LOW      = 5'h01;
   localparam logic [7:0]  OP_NOP        = 8'h00;
   localparam logic [7:0]  OP_INC_A      = 8'h04;
   localparam logic [7:0]  OP_DEC_A      = 8'h14;
   localparam logic [7:0]  OP_INC_DATA_POINTER_16   = 8'ha3;
   localparam logic [7:0]  OP_MUL        = 8'ha4;
   localparam logic [7:0]  OP_DIV        = 8'h84;
   localparam logic [7:0]  OP_AND_DIR_A  = 8'h52;
   localparam logic [7:0]  OP_AND_DIR_I  = 8'h53;
   localparam logic [7:0]  OP_PUSH       = 8'hc0;
   localparam logic [7:0]  OP_SJMP       = 8'h80;
   localparam logic [7:0]  OP_MOV_DIR_I  = 8'h75;
   localparam logic [7:0]  OP_SETB_BIT   = 8'hd2;
   localparam logic [7:0]  OP_CLR_BIT    = 8'hc2;

   // Instruction lengths in bytes
   localparam logic [2:0]  BYTES_1       = 3'd1;
   localparam logic [2:0]  BYTES_2       = 3'd2;
   localparam logic [2:0]  BYTES_3       = 3'd3;

   // Instruction durations in cycles
   localparam logic [2:0]  CYC_1         = 3'd1;
   localparam logic [2:0]  CYC_2         = 3'd2;
   localparam logic [2:0]  CYC_3         = 3'd3;
   localparam logic [2:0]  CYC_4         = 3'd4;
   localparam logic [2:0]  CYC_5         = 3'd5;

   // Arithmetic operation selected by the opcode group
   typedef enum logic [1:0] {
      ALU_ADD,
      ALU_ADD_WITH_CARRY_IN,
      ALU_SUBTRACT_WITH_BORROW,
      ALU_AND
   } ccra_alu_t;

endpackage : ccra_pkg

/* rtl/ccra_core.sv */
// Purpose : CPU core architectural registers and arithmetic/logic datapath
// Assumes : Code memory answers combinationally to o_code_addr; internal data memory lives here
// Notes   : Unlisted opcodes run as one-cycle no-operations
`timescale 1ns/10ps

module ccra_core (
   // Clock and reset
   input  wire logic                       i_clk,
   input  wire logic                       i_reset,
   // Code memory
   output logic [ccra_pkg::PC_W-1:0]       o_code_addr,
   input  wire logic [7:0]                 i_code_data,
   // Architectural state
   output logic [7:0]                      o_main_operand,
   output logic [7:0]                      o_second_operand,
   output logic [7:0]                      o_cpu_status_word,
   output logic [7:0]                      o_stack_top_pointer,
   output logic [15:0]                     o_data_pointer_16,
   // Instruction boundary
   output logic                            o_insn_start
);
   import ccra_pkg::*;

   // State
   logic [PC_W-1:0]  pc_r;
   logic [PC_W-1:0]  pc_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic [7:0]       op_r;
   logic [7:0]       b1_r;
   logic [7:0]       b2_r;
   logic [7:0]       acc_r;
   logic [7:0]       acc_nxt;
   logic [7:0]       b_r;
   logic [7:0]       b_nxt;
   logic [7:0]       psw_r;
   logic [7:0]       psw_nxt;
   logic [7:0]       sp_r;
   logic [7:0]       sp_nxt;
   logic [15:0]      data_pointer_16_r;
   logic [15:0]      data_pointer_16_nxt;
   logic             start_r;
   logic [7:0]       ram [0:255];

   // Decode
   logic [7:0]       op;
   logic             grp_alu;
   logic             src_rn;
   logic             src_ri;
   logic             src_dir;
   logic             is_ajmp;
   logic             is_bit;
   logic [2:0]       n_bytes;
   logic [2:0]       n_cyc;
   logic [CNT_W-1:0] cnt_inc;
   logic             last;
   logic             fetch_byte;
   logic [7:0]       b1;
   logic [7:0]       b2;
   ccra_alu_t        alu_op;

   // Operand access
   logic [1:0]       bank;
   logic [7:0]       rn_addr;
   logic [7:0]       ri_ptr_addr;
   logic [7:0]       ri_addr;
   logic [7:0]       bit_byte;
   logic [7:0]       rd_addr;
   logic [7:0]       sfr_val;
   logic [7:0]       dir_val;
   logic [7:0]       alu_src;
   logic [7:0]       bit_mask;

   // Arithmetic
   logic             cin;
   logic [8:0]       sum9;
   logic [4:0]       sum_lo5;
   logic [8:0]       dif9;
   logic [4:0]       dif_lo5;
   logic [15:0]      prod;
   logic [7:0]       quo;
   logic [7:0]       rem;
   logic [7:0]       stack_addr;
   logic [15:0]      rel_ext;

   // Execute results
   logic [7:0]       acc_a;
   logic [7:0]       b_a;
   logic [7:0]       sp_a;
   logic [15:0]      data_pointer_16_a;
   logic             flag_wr;
   logic             ac_wr;
   logic             cy_v;
   logic             ac_v;
   logic             ov_v;
   logic             wr_en;
   logic             wr_dir;
   logic [7:0]       wr_addr;
   logic [7:0]       wr_data;
   logic             jump;
   logic [PC_W-1:0]  jtarget;
   logic             sfr_we;
   logic             ram_we;
   logic [7:0]       psw_w;

   // Opcode is on the code bus in the first cycle and held afterwards
   assign op          = (cnt_r == '0) ? i_code_data : op_r;
   assign grp_alu     = ((op[7:4] == GRP_ADD) || (op[7:4] == GRP_ADD_WITH_CARRY_IN) ||
                         (op[7:4] == GRP_SUBTRACT_WITH_BORROW) || (op[7:4] == GRP_AND)) && (op[3:0] >= LO_IMM);
   assign src_rn      = op[3];
   assign src_ri      = (op[3:1] == 3'b011);
   assign src_dir     = (op[3:0] == LO_DIR);
   assign is_ajmp     = (op[4:0] == AJMP_LOW);
   assign is_bit      = (op == OP_SETB_BIT) || (op == OP_CLR_BIT);
   assign alu_op      = (op[7:4] == GRP_ADD)  ? ALU_ADD  :
                        (op[7:4] == GRP_ADD_WITH_CARRY_IN) ? ALU_ADD_WITH_CARRY_IN :
                        (op[7:4] == GRP_SUBTRACT_WITH_BORROW) ? ALU_SUBTRACT_WITH_BORROW : ALU_AND;

   // Byte and cycle counts per opcode
   assign n_bytes     = grp_alu ? ((src_rn || src_ri) ? BYTES_1 : BYTES_2) :
                        ((op == OP_AND_DIR_I) || (op == OP_MOV_DIR_I)) ? BYTES_3 :
                        ((op == OP_AND_DIR_A) || (op == OP_PUSH) || (op == OP_SJMP) ||
                         is_ajmp || is_bit) ? BYTES_2 : BYTES_1;
   assign n_cyc       = grp_alu ? (src_rn ? CYC_1 : CYC_2) :
                        ((op == OP_MUL) || (op == OP_DIV)) ? CYC_5 :
                        ((op == OP_AND_DIR_I) || (op == OP_PUSH)) ? CYC_4 :
                        ((op == OP_AND_DIR_A) || (op == OP_SJMP) || is_ajmp ||
                         (op == OP_MOV_DIR_I) || is_bit) ? CYC_3 : CYC_1;

   // Sequencing: bytes are fetched one per cycle from the start, execution in the final cycle
   assign cnt_inc     = cnt_r + 3'd1;
   assign last        = (cnt_inc == n_cyc);
   assign fetch_byte  = (cnt_r < n_bytes);
   assign b1          = (cnt_r == 3'd1) ? i_code_data : b1_r;
   assign b2          = (cnt_r == 3'd2) ? i_code_data : b2_r;

   // Register bank and indirect pointer
   assign bank        = psw_r[RS_HI:RS_LO];
   assign rn_addr     = {3'b000, bank, op[2:0]};
   assign ri_ptr_addr = {3'b000, bank, 2'b00, op[0]};
   assign ri_addr     = ram[ri_ptr_addr];

   // Direct read port, shared by byte and bit operands
   assign bit_byte    = b1[7] ? {b1[7:3], 3'b000} : (BIT_AREA_BASE + {4'h0, b1[6:3]});
   assign rd_addr     = is_bit ? bit_byte : b1;
   assign sfr_val     = (rd_addr == SFR_SP)  ? sp_r :
                        (rd_addr == SFR_DPL) ? data_pointer_16_r[7:0] :
                        (rd_addr == SFR_DPH) ? data_pointer_16_r[15:8] :
                        (rd_addr == SFR_PSW) ? psw_r :
                        (rd_addr == SFR_ACC) ? acc_r :
                        (rd_addr == SFR_B)   ? b_r : 8'h00;
   assign dir_val     = rd_addr[7] ? sfr_val : ram[rd_addr];
   assign alu_src     = src_rn ? ram[rn_addr] :
                        src_ri ? ram[ri_addr] :
                        src_dir ? dir_val : b1;
   assign bit_mask    = 8'h01 << b1[2:0];

   // Adder and subtractor, full byte and low nibble
   assign cin         = (alu_op == ALU_ADD_WITH_CARRY_IN) ? psw_r[CY_BIT] : 1'b0;
   assign sum9        = {1'b0, acc_r} + {1'b0, alu_src} + {8'h00, cin};
   assign sum_lo5     = {1'b0, acc_r[3:0]} + {1'b0, alu_src[3:0]} + {4'h0, cin};
   assign dif9        = {1'b0, acc_r} - {1'b0, alu_src} - {8'h00, psw_r[CY_BIT]};
   assign dif_lo5     = {1'b0, acc_r[3:0]} - {1'b0, alu_src[3:0]} - {4'h0, psw_r[CY_BIT]};

   // Multiply and divide; a zero divisor keeps both operands to avoid an undefined quotient
   assign prod        = {8'h00, acc_r} * {8'h00, b_r};
   assign quo         = (b_r == 8'h00) ? acc_r : acc_r / b_r;
   assign rem         = (b_r == 8'h00) ? b_r : acc_r % b_r;

   assign stack_addr  = sp_r + 8'h01;
   assign rel_ext     = {{8{b1[7]}}, b1};

   // Execute
   always_comb begin
      acc_a   = acc_r;
      b_a     = b_r;
      sp_a    = sp_r;
      data_pointer_16_a  = data_pointer_16_r;
      flag_wr = 1'b0;
      ac_wr   = 1'b0;
      cy_v    = 1'b0;
      ac_v    = 1'b0;
      ov_v    = 1'b0;
      wr_en   = 1'b0;
      wr_dir  = 1'b1;
      wr_addr = b1;
      wr_data = 8'h00;
      jump    = 1'b0;
      jtarget = pc_r;
      if (last) begin
         if (grp_alu) begin
            unique case (alu_op)
               ALU_ADD, ALU_ADD_WITH_CARRY_IN: begin
                  acc_a   = sum9[7:0];
                  flag_wr = 1'b1;
                  ac_wr   = 1'b1;
                  cy_v    = sum9[8];
                  ac_v    = sum_lo5[4];
                  ov_v    = sum9[8];
               end
               ALU_SUBTRACT_WITH_BORROW: begin
                  acc_a   = dif9[7:0];
                  flag_wr = 1'b1;
                  ac_wr   = 1'b1;
                  cy_v    = dif9[8];
                  ac_v    = dif_lo5[4];
                  ov_v    = dif9[8];
               end
               ALU_AND: begin
                  acc_a   = acc_r & alu_src;
               end
            endcase
         end else if (is_ajmp) begin
            jump    = 1'b1;
            jtarget = {pc_r[15:11], op[7:5], b1};
         end else begin
            case (op)
               OP_INC_A:     acc_a = acc_r + 8'h01;
               OP_DEC_A:     acc_a = acc_r - 8'h01;
               OP_INC_DATA_POINTER_16:  data_pointer_16_a = data_pointer_16_r + 16'h0001;
               OP_MUL: begin
                  acc_a   = prod[7:0];
                  b_a     = prod[15:8];
                  flag_wr = 1'b1;
                  ov_v    = (prod[15:8] != 8'h00);
               end
               OP_DIV: begin
                  acc_a   = quo;
                  b_a     = rem;
                  flag_wr = 1'b1;
                  ov_v    = (b_r == 8'h00);
               end
               OP_AND_DIR_A: begin
                  wr_en   = 1'b1;
                  wr_data = dir_val & acc_r;
               end
               OP_AND_DIR_I: begin
                  wr_en   = 1'b1;
                  wr_data = dir_val & b2;
               end
               OP_MOV_DIR_I: begin
                  wr_en   = 1'b1;
                  wr_data = b2;
               end
               OP_SETB_BIT, OP_CLR_BIT: begin
                  wr_en   = 1'b1;
                  wr_addr = bit_byte;
                  wr_data = (op == OP_SETB_BIT) ? (dir_val | bit_mask) : (dir_val & ~bit_mask);
               end
               OP_PUSH: begin
                  sp_a    = stack_addr;
                  wr_en   = 1'b1;
                  wr_dir  = 1'b0;
                  wr_addr = stack_addr;
                  wr_data = dir_val;
               end
               OP_SJMP: begin
                  jump    = 1'b1;
                  jtarget = pc_r + rel_ext;
               end
               default: ;
            endcase
         end
      end
   end

   // Write port split between registers and data memory
   assign sfr_we   = wr_en & wr_dir & wr_addr[7];
   assign ram_we   = wr_en & ~sfr_we;
   assign acc_nxt  = (sfr_we && (wr_addr == SFR_ACC)) ? wr_data : acc_a;
   assign b_nxt    = (sfr_we && (wr_addr == SFR_B)) ? wr_data : b_a;
   assign sp_nxt   = (sfr_we && (wr_addr == SFR_SP)) ? wr_data : sp_a;
   assign data_pointer_16_nxt = (sfr_we && (wr_addr == SFR_DPL)) ? {data_pointer_16_a[15:8], wr_data} :
                     (sfr_we && (wr_addr == SFR_DPH)) ? {wr_data, data_pointer_16_a[7:0]} : data_pointer_16_a;
   assign psw_w    = (sfr_we && (wr_addr == SFR_PSW)) ? wr_data : psw_r;

   // Parity is recomputed from the next accumulator, so a written parity bit never sticks
   assign psw_nxt  = {flag_wr ? cy_v : psw_w[CY_BIT],
                      ac_wr ? ac_v : psw_w[AC_BIT],
                      psw_w[F0_BIT],
                      psw_w[RS_HI:RS_LO],
                      flag_wr ? ov_v : psw_w[OV_BIT],
                      psw_w[F1_BIT],
                      ^acc_nxt};

   assign pc_nxt   = jump ? jtarget : (fetch_byte ? pc_r + 16'h0001 : pc_r);
   assign cnt_nxt  = last ? '0 : cnt_inc;

   // Sequencer and operand latches
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         pc_r    <= PC_RESET;
         cnt_r   <= '0;
         op_r    <= OP_NOP;
         b1_r    <= 8'h00;
         b2_r    <= 8'h00;
         start_r <= 1'b1;
      end else begin
         pc_r    <= pc_nxt;
         cnt_r   <= cnt_nxt;
         if (cnt_r == 3'd0) op_r <= i_code_data;
         if (cnt_r == 3'd1) b1_r <= i_code_data;
         if (cnt_r == 3'd2) b2_r <= i_code_data;
         start_r <= last;
      end
   end

   // Architectural registers
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         acc_r  <= ACC_RESET;
         b_r    <= B_RESET;
         psw_r  <= PSW_RESET;
         sp_r   <= SP_RESET;
         data_pointer_16_r <= DATA_POINTER_16_RESET;
      end else begin
         acc_r  <= acc_nxt;
         b_r    <= b_nxt;
         psw_r  <= psw_nxt;
         sp_r   <= sp_nxt;
         data_pointer_16_r <= data_pointer_16_nxt;
      end
   end

   // Internal data memory; contents are undefined after reset like any RAM
   always_ff @(posedge i_clk) begin
      if (ram_we) ram[wr_addr] <= wr_data;
   end

   assign o_code_addr         = pc_r;
   assign o_main_operand      = acc_r;
   assign o_second_operand    = b_r;
   assign o_cpu_status_word   = psw_r;
   assign o_stack_top_pointer = sp_r;
   assign o_data_pointer_16   = data_pointer_16_r;
   assign o_insn_start        = start_r;

endmodule : ccra_core

/* verif/ccra_core_checker.sv */
// Purpose: Port-level timing and flag checks for the core
// Assumes: Code bytes are valid in the cycle they are addressed
// Notes  : Register outputs are compared one edge after the cause
`timescale 1ns/10ps
module ccra_core_checker
   import ccra_pkg::*;
(
   // Clock and reset
   input wire logic            i_clk,
   input wire logic            i_reset,
   // Core ports
   input wire logic [PC_W-1:0] o_code_addr,
   input wire logic [7:0]      i_code_data,
   input wire logic [7:0]      o_main_operand,
   input wire logic [7:0]      o_second_operand,
   input wire logic [7:0]      o_cpu_status_word,
   input wire logic [7:0]      o_stack_top_pointer,
   input wire logic [15:0]     o_data_pointer_16,
   input wire logic            o_insn_start
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   wire logic op_take = o_insn_start;

   parity_track_a: assert property (o_cpu_status_word[P_BIT] == ^o_main_operand)
      else $error("parity bit differs from accumulator");
   reset_values_a: assert property ($fell(i_reset) |-> o_insn_start && o_code_addr == PC_RESET
      && o_stack_top_pointer == SP_RESET && o_main_operand == ACC_RESET && o_cpu_status_word == PSW_RESET)
      else $error("state after reset is wrong");
   mul_timing_a: assert property (op_take && i_code_data == OP_MUL |=> !o_insn_start [*4] ##1 o_insn_start)
      else $error("multiply does not take five cycles");
   div_timing_a: assert property (op_take && i_code_data == OP_DIV |=> !o_insn_start [*4] ##1 o_insn_start)
      else $error("divide does not take five cycles");
   inc_acc_a: assert property (op_take && i_code_data == OP_INC_A |=> o_insn_start
      && o_main_operand == $past(o_main_operand) + 8'h01)
      else $error("increment of accumulator wrong");
   dec_acc_a: assert property (op_take && i_code_data == OP_DEC_A |=> o_insn_start
      && o_main_operand == $past(o_main_operand) - 8'h01 && $stable(o_cpu_status_word[7:1]))
      else $error("decrement of accumulator wrong");
   add_imm_a: assert property (op_take && i_code_data == 8'h24 |=> !o_insn_start ##1
      (o_insn_start && o_code_addr == $past(o_code_addr, 2) + 16'h0002))
      else $error("add immediate timing wrong");
   reg_add_a: assert property (op_take && i_code_data[7:3] == 5'h05 |=>
      o_insn_start && o_code_addr == $past(o_code_addr) + 16'h0001)
      else $error("add from banked register timing wrong");
   push_order_a: assert property (op_take && i_code_data == OP_PUSH |=> ##3
      (o_insn_start && o_stack_top_pointer == $past(o_stack_top_pointer, 4) + 8'h01))
      else $error("push did not advance the stack pointer by one");

   mul_seen_c: cover property (op_take && i_code_data == OP_MUL);
   push_seen_c: cover property (op_take && i_code_data == OP_PUSH);
   jump_seen_c: cover property (op_take && i_code_data[4:0] == AJMP_LOW);
endmodule : ccra_core_checker

bind ccra_core ccra_core_checker u_ccra_core_checker (.i_clk(i_clk), .i_reset(i_reset),
   .o_code_addr(o_code_addr), .i_code_data(i_code_data), .o_main_operand(o_main_operand),
   .o_second_operand(o_second_operand), .o_cpu_status_word(o_cpu_status_word),
   .o_stack_top_pointer(o_stack_top_pointer), .o_data_pointer_16(o_data_pointer_16),
   .o_insn_start(o_insn_start));

/* verif/ccra_code_rom.sv */
// Purpose: Code memory facing the core, answering in the same cycle
// Assumes: The bench fills the array during reset; t_branch loads its jump targets just after releasing it
// Notes  : Only 4 KB is modelled; higher addresses alias into it
`timescale 1ns/10ps
module ccra_code_rom (
   // Code bus
   input  wire logic [15:0] i_addr,
   output logic      [7:0]  o_data
);
   logic [7:0] mem [0:4095];
   assign o_data = mem[i_addr[11:0]];
endmodule : ccra_code_rom

/* verif/tb_top.sv */
// Purpose: Self-checking bench running short programs on the core
// Assumes: Programs stop on filler bytes, which run as one-cycle no-ops
// Notes  : Every stop also checks the cycle count since the last stop
`timescale 1ns/10ps
module tb_top;
   import ccra_pkg::*;
   typedef logic [7:0] ccra_bytes_t [$];
   logic            i_clk;
   logic            i_reset;
   logic [PC_W-1:0] o_code_addr;
   logic [7:0]      i_code_data;
   logic [7:0]      o_main_operand;
   logic [7:0]      o_second_operand;
   logic [7:0]      o_cpu_status_word;
   logic [7:0]      o_stack_top_pointer;
   logic [15:0]     o_data_pointer_16;
   logic            o_insn_start;
   int              errors;
   int              total_checks;

   ccra_core u_ccra_core (.i_clk(i_clk), .i_reset(i_reset), .o_code_addr(o_code_addr),
      .i_code_data(i_code_data), .o_main_operand(o_main_operand), .o_second_operand(o_second_operand),
      .o_cpu_status_word(o_cpu_status_word), .o_stack_top_pointer(o_stack_top_pointer),
      .o_data_pointer_16(o_data_pointer_16), .o_insn_start(o_insn_start));
   ccra_code_rom u_ccra_code_rom (.i_addr(o_code_addr), .o_data(i_code_data));

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic st(input logic [7:0] a, input logic [7:0] b, input logic [7:0] p);
      chk(16'(o_main_operand), 16'(a));
      chk(16'(o_second_operand), 16'(b));
      chk(16'(o_cpu_status_word), 16'(p));
   endtask : st

   task automatic load(input logic [15:0] base, input ccra_bytes_t b);
      foreach (b[i]) u_ccra_code_rom.mem[base + i] = b[i];
   endtask : load

   // Memory is wiped each time so a stray jump lands on no-ops, not on old code
   task automatic start(input ccra_bytes_t b);
      @(posedge i_clk);
      #1 i_reset = 1'b1;
      foreach (u_ccra_code_rom.mem[i]) u_ccra_code_rom.mem[i] = 8'h00;
      load(16'h0000, b);
      @(posedge i_clk);
      @(posedge i_clk);
      #1 i_reset = 1'b0;
   endtask : start

   // Runs until an opcode fetch at addr; a hang fails the count and ends the run
   task automatic go(input logic [15:0] addr, input int cyc);
      int n;
      n = 0;
      do begin
         @(posedge i_clk);
         #1 n++;
      end while (!(o_insn_start === 1'b1 && o_code_addr === addr) && n < 300);
      chk(16'(n), 16'(cyc));
      if (n >= 300) conclude();
   endtask : go

   task automatic t_reset();
      start('{8'h00});
      st(8'h00, 8'h00, 8'h00);
      chk(16'(o_stack_top_pointer), 16'h0007);
      chk(o_code_addr, 16'h0000);
   endtask : t_reset

   task automatic t_arith();
      start('{8'h75, 8'he0, 8'h8f, 8'h24, 8'h71, 8'h34, 8'h00, 8'h94, 8'h02, 8'h94, 8'h0f});
      go(16'h0005, 5);
      st(8'h00, 8'h00, 8'hc4);
      go(16'h0007, 2);
      st(8'h01, 8'h00, 8'h01);
      go(16'h0009, 2);
      st(8'hff, 8'h00, 8'hc4);
      go(16'h000b, 2);
      st(8'hef, 8'h00, 8'h41);
   endtask : t_arith

   task automatic t_bank();
      start('{8'h75, 8'h18, 8'h21, 8'h75, 8'h1f, 8'h02, 8'h75, 8'hd0, 8'h18, 8'h75, 8'he0, 8'h10, 8'h28, 8'h3f});
      go(16'h000e, 14);
      st(8'h33, 8'h00, 8'h18);
   endtask : t_bank

   task automatic t_stack();
      start('{8'h75, 8'h81, 8'h8f, 8'h75, 8'he0, 8'h3c, 8'hc0, 8'he0, 8'h75, 8'h90, 8'h55,
              8'h75, 8'h00, 8'h90, 8'h75, 8'he0, 8'h01, 8'h26});
      go(16'h0008, 10);
      chk(16'(o_stack_top_pointer), 16'h0090);
      go(16'h0012, 11);
      st(8'h3d, 8'h00, 8'h01);
   endtask : t_stack

   task automatic t_muldiv();
      start('{8'hd2, 8'hd7, 8'h75, 8'he0, 8'h20, 8'h75, 8'hf0, 8'h10, 8'ha4, 8'h75, 8'he0, 8'h64,
              8'h75, 8'hf0, 8'h07, 8'h84, 8'h75, 8'hf0, 8'h00, 8'h84});
      go(16'h0009, 14);
      st(8'h00, 8'h02, 8'h04);
      go(16'h0010, 11);
      st(8'h0e, 8'h02, 8'h01);
      go(16'h0014, 8);
      st(8'h0e, 8'h00, 8'h05);
   endtask : t_muldiv

   task automatic t_incdec();
      start('{8'hd2, 8'hd7, 8'h75, 8'he0, 8'hff, 8'h04, 8'h14, 8'ha3, 8'h54, 8'h3c, 8'h53, 8'he0, 8'h0f,
              8'h75, 8'hf0, 8'h36, 8'h52, 8'hf0});
      go(16'h0006, 7);
      st(8'h00, 8'h00, 8'h80);
      go(16'h0008, 2);
      st(8'hff, 8'h00, 8'h80);
      chk(o_data_pointer_16, 16'h0001);
      go(16'h0012, 12);
      st(8'h0c, 8'h04, 8'h80);
   endtask : t_incdec

   task automatic t_flags();
      start('{8'hd2, 8'hd5, 8'hd2, 8'hd1, 8'hc2, 8'hd5, 8'h75, 8'hd0, 8'hff, 8'h24, 8'h00});
      go(16'h0004, 6);
      chk(16'(o_cpu_status_word), 16'h0022);
      go(16'h0006, 3);
      chk(16'(o_cpu_status_word), 16'h0002);
      go(16'h0009, 3);
      chk(16'(o_cpu_status_word), 16'h00fe);
      go(16'h000b, 2);
      chk(16'(o_cpu_status_word), 16'h003a);
   endtask : t_flags

   // The last jump sits at the end of a page, so its target page is the next one
   task automatic t_branch();
      start('{8'h80, 8'h7f});
      load(16'h0081, '{8'h80, 8'h80});
      load(16'h0003, '{8'ha1, 8'ha5});
      load(16'h05a5, '{8'he1, 8'hfe});
      load(16'h07fe, '{8'h01, 8'h10});
      go(16'h0081, 3);
      go(16'h0003, 3);
      go(16'h05a5, 3);
      go(16'h07fe, 3);
      go(16'h0810, 3);
   endtask : t_branch

   initial begin
      errors = 0;
      total_checks = 0;
      i_reset = 1'b1;
      foreach (u_ccra_code_rom.mem[i]) u_ccra_code_rom.mem[i] = 8'h00;
      repeat (16) @(posedge i_clk);
      t_reset();
      t_arith();
      t_bank();
      t_stack();
      t_muldiv();
      t_incdec();
      t_flags();
      t_branch();
      conclude();
   end
endmodule : tb_top
